// >>> dec_consts.vh
`ifndef DEC_CONSTS_VH
`define DEC_CONSTS_VH
// printed offsets (not all multiples of four): kept as indices, byte address = 4 * index
`define DEC_IDX_CTL        12'h048
`define DEC_IDX_STS        12'h04a
`define DEC_IDX_IRQ_STS    12'h060
`define DEC_IDX_IRQ_EN     12'h061
`define DEC_IDX_IRQ_CLR    12'h062
`define DEC_ADDR_W         14
`define DEC_CTL_RESET      16'h0000
`define DEC_STS_RESET      4'h0
`define DEC_CTL_EN_LSB     0
`define DEC_CTL_EN_MSB     3
`define DEC_CTL_PL_LSB     5
`define DEC_CTL_PL_MSB     7
`define DEC_CTL_ETAG_BIT   8
`define DEC_PL_RESET       3'h0
`define DEC_PL_MAX_CODE    3'h4
`define DEC_PL_CAP         3'h4
`define DEC_PL_BASE_BYTES  12'h080
`define DEC_IRQ_W          4
`endif

// >>> dec_ctrl_status.v
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ns
`include "dec_consts.vh"

module dec_ctrl_status (
   input  wire                    clk,
   input  wire                    rst_b,
   input  wire [`DEC_ADDR_W-1:0]  addr,
   input  wire [31:0]             wdata,
   input  wire                    wr,
   input  wire                    rd,
   output reg  [31:0]             rdata,
   input  wire                    det_correctable,
   input  wire                    det_nonfatal,
   input  wire                    det_fatal,
   input  wire                    det_unsupported,
   output reg                     msg_correctable,
   output reg                     msg_nonfatal,
   output reg                     msg_fatal,
   output reg                     msg_unsupported,
   output reg  [11:0]             payload_limit_bytes,
   output wire [2:0]              payload_capability,
   output wire                    own_relaxed_order,
   output wire                    own_no_snoop,
   output wire [11:0]             own_max_request_bytes,
   output wire                    irq
);

   reg  [3:0]  report_enable_reg;
   reg  [2:0]  payload_limit_reg;
   reg         extended_tag_enable_reg;
   reg  [3:0]  error_flag_reg;
   reg  [3:0]  error_flag_next;
   reg  [3:0]  irq_sts_reg;
   reg  [3:0]  irq_sts_next;
   reg  [3:0]  irq_en_reg;
   reg  [31:0] rdata_next;
   wire [3:0]  det;
   wire [15:0] ctl_view;
   wire [15:0] sts_view;
   wire        sel_ctl;
   wire        sel_sts;
   wire        sel_isr;
   wire        sel_ien;
   wire        sel_icl;

   // decodes a word-aligned byte address against a register index
   function hit;
      input [`DEC_ADDR_W-1:0] a;
      input [11:0]            idx;
      begin
         hit = (a[`DEC_ADDR_W-1:2] == idx) && (a[1:0] == 2'b00);
      end
   endfunction

   // reserved codes fall back to the smallest size
   function [11:0] pl_bytes;
      input [2:0] code;
      begin
         if (code > `DEC_PL_MAX_CODE)
            pl_bytes = `DEC_PL_BASE_BYTES;
         else
            pl_bytes = `DEC_PL_BASE_BYTES << code;
      end
   endfunction

   assign det     = {det_unsupported, det_fatal, det_nonfatal, det_correctable};
   assign sel_ctl = hit(addr, `DEC_IDX_CTL);
   assign sel_sts = hit(addr, `DEC_IDX_STS);
   assign sel_isr = hit(addr, `DEC_IDX_IRQ_STS);
   assign sel_ien = hit(addr, `DEC_IDX_IRQ_EN);
   assign sel_icl = hit(addr, `DEC_IDX_IRQ_CLR);

   // hardwired bits 4, 9..15 read zero
   assign ctl_view = {7'h00, extended_tag_enable_reg, payload_limit_reg, 1'b0,
                      report_enable_reg};
   // bits 4, 5 and above read zero
   assign sts_view = {12'h000, error_flag_reg};

   assign payload_capability    = `DEC_PL_CAP;
   assign own_relaxed_order     = 1'b0;
   assign own_no_snoop          = 1'b0;
   assign own_max_request_bytes = `DEC_PL_BASE_BYTES;
   assign irq                   = |(irq_sts_reg & irq_en_reg);

   // set wins over a same-cycle write-one clear
   always @*
   begin
      error_flag_next = error_flag_reg;
      if (wr && sel_sts)
         error_flag_next = error_flag_next & ~wdata[`DEC_IRQ_W-1:0];
      error_flag_next = error_flag_next | det;
      irq_sts_next = irq_sts_reg;
      if (wr && sel_icl)
         irq_sts_next = irq_sts_next & ~wdata[`DEC_IRQ_W-1:0];
      irq_sts_next = irq_sts_next | det;
   end

   always @*
   begin
      rdata_next = 32'h0000_0000;
      if (sel_ctl)
         rdata_next = {16'h0000, ctl_view};
      else if (sel_sts)
         rdata_next = {16'h0000, sts_view};
      else if (sel_isr)
         rdata_next = {28'h0000000, irq_sts_reg};
      else if (sel_ien)
         rdata_next = {28'h0000000, irq_en_reg};
   end

   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         report_enable_reg       <= `DEC_STS_RESET;
         payload_limit_reg       <= `DEC_PL_RESET;
         extended_tag_enable_reg <= 1'b0;
         error_flag_reg          <= `DEC_STS_RESET;
         irq_sts_reg             <= `DEC_STS_RESET;
         irq_en_reg              <= `DEC_STS_RESET;
         rdata                   <= 32'h0000_0000;
         msg_correctable         <= 1'b0;
         msg_nonfatal            <= 1'b0;
         msg_fatal               <= 1'b0;
         msg_unsupported         <= 1'b0;
         payload_limit_bytes     <= `DEC_PL_BASE_BYTES;
      end
      else
      begin
         if (wr && sel_ctl)
         begin
            report_enable_reg       <= wdata[`DEC_CTL_EN_MSB:`DEC_CTL_EN_LSB];
            payload_limit_reg       <= wdata[`DEC_CTL_PL_MSB:`DEC_CTL_PL_LSB];
            extended_tag_enable_reg <= wdata[`DEC_CTL_ETAG_BIT];
         end
         if (wr && sel_ien)
            irq_en_reg <= wdata[`DEC_IRQ_W-1:0];
         error_flag_reg <= error_flag_next;
         irq_sts_reg    <= irq_sts_next;
         if (rd)
            rdata <= rdata_next;
         else
            rdata <= 32'h0000_0000;
         // one-cycle message request per detection, gated by its enable
         msg_correctable     <= det_correctable & report_enable_reg[0];
         msg_nonfatal        <= det_nonfatal & report_enable_reg[1];
         msg_fatal           <= det_fatal & report_enable_reg[2];
         msg_unsupported     <= det_unsupported & report_enable_reg[3];
         payload_limit_bytes <= pl_bytes(payload_limit_reg);
      end
   end

endmodule // dec_ctrl_status

// >>> dec_ctrl_status_properties.sv
`timescale 1ns/1ns
module dec_chk (
   input wire        clk,
   input wire        rst_b,
   input wire        rd,
   input wire [31:0] rdata,
   input wire        det_correctable,
   input wire        det_fatal,
   input wire        msg_correctable,
   input wire        msg_fatal,
   input wire [11:0] payload_limit_bytes,
   input wire [2:0]  payload_capability,
   input wire        own_relaxed_order,
   input wire        own_no_snoop,
   input wire [11:0] own_max_request_bytes
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   AST_CAP: assert property (payload_capability == 3'h4) else $error("cap");
   AST_OWN: assert property (!own_relaxed_order && !own_no_snoop) else $error("attr");
   AST_REQ: assert property (own_max_request_bytes == 12'h080) else $error("req");
   AST_PL: assert property ($onehot(payload_limit_bytes) && payload_limit_bytes >= 12'h080)
      else $error("payload");
   AST_MF: assert property (msg_fatal |-> $past(det_fatal)) else $error("fatal msg");
   AST_MC: assert property (msg_correctable |-> $past(det_correctable)) else $error("c msg");
   AST_HI: assert property (rd |=> rdata[31:16] == 16'h0000) else $error("upper");
   AST_IDLE: assert property (!rd |=> rdata == 32'h0) else $error("idle data");
endmodule // dec_chk
bind dec_ctrl_status dec_chk u_chk (.*);

// >>> testbench.sv
`timescale 1ns/1ns
module testbench;
   localparam A_CTL = 14'h120, A_STS = 14'h128, A_IST = 14'h180, A_IEN = 14'h184, A_ICL = 14'h188;
   logic        clk = 0, rst_b = 0, wr = 0, rd = 0, irq;
   logic [13:0] addr = 0;
   logic [31:0] wdata = 0, rdata, got;
   logic [3:0]  det = 0, msg, m;
   logic [11:0] plb;
   logic [15:0] v;
   int          errors = 0, n_compared = 0, cyc = 0, i;
   always #25 clk = ~clk;
   dec_ctrl_status u_dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .det_correctable(det[0]), .det_nonfatal(det[1]),
      .det_fatal(det[2]), .det_unsupported(det[3]), .msg_correctable(msg[0]),
      .msg_nonfatal(msg[1]), .msg_fatal(msg[2]), .msg_unsupported(msg[3]),
      .payload_limit_bytes(plb), .payload_capability(), .own_relaxed_order(),
      .own_no_snoop(), .own_max_request_bytes(), .irq(irq));
   task stop_test(input int t);
      errors += t;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      if (g !== e)
         errors++;
   endtask
   task wr_t(input logic [13:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_t(input logic [13:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 got = rdata;
   endtask
   task pulse(input logic [3:0] d);
      @(posedge clk);
      det <= d;
      @(posedge clk);
      det <= 4'h0;
      #1;
   endtask
   // reserved codes fall back to the smallest payload
   function logic [11:0] pl_exp(input int c);
      return (c < 5) ? 12'h080 << c : 12'h080;
   endfunction
   always @(posedge clk)
      if (++cyc == 3000)
         stop_test(1);
   initial
   begin
      got = $urandom(32'hddf075f9);
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      rd_t(A_CTL); chk(got, 0);
      rd_t(A_STS); chk(got, 0);
      for (i = 0; i < 8; i++)
      begin
         v = $urandom;
         v[7:5] = i;
         wr_t(A_CTL, {$urandom, v});
         @(posedge clk);
         #1 chk(plb, pl_exp(i));
         rd_t(A_CTL); chk(got, v & 16'h01ef);
      end
      wr_t(A_CTL, 32'hf);
      pulse(4'hf); chk(msg, 4'hf);
      wr_t(A_CTL, 32'h0);
      m = $urandom;
      pulse(m); chk(msg, 0);
      rd_t(A_STS); chk(got, 32'hf);
      m = $urandom;
      wr_t(A_STS, {$urandom, m});
      rd_t(A_STS); chk(got, ~m & 4'hf);
      wr_t(A_IEN, 32'h4);
      rd_t(A_IEN); chk({got, irq}, 33'h9);
      wr_t(A_ICL, 32'h4);
      rd_t(A_IST); chk({got, irq}, 33'h16);
      rd_t(14'h3ffc); chk(got, 0);
      // mid-run reset must bring every field back to zero, drop irq and return plb to 12'h080
      @(posedge clk);
      rst_b <= 1'b0;
      @(posedge clk);
      rst_b <= 1'b1;
      #1 chk({plb, irq}, 13'h100);
      rd_t(A_CTL); chk(got, 0);
      rd_t(A_STS); chk(got, 0);
      stop_test(0);
   end
endmodule // testbench
